// >>> core/fmpc_ctrl.sv
// flash map and protect controller: registers, commit logic, standby guard
// assumes an APB master on pclk, a core giving accesses on the same clock,
// and a serial programming mode strap arriving asynchronously on a pin
`timescale 1ns/1ns

// Notes on behaviour
// - flash access during standby resets the device
// - standby register always reads zero
// - clock pin input gated by its bit
// - other port inputs gated by their bit
// - port gate inert, reads zero outside serial
// - commands enabled by code 101 plus D5
// - disabled commands and toggles are dropped
// - command code resets to 010
// - disabling rejects new writes, no abort
// - window 01 folds data upper half down
// - window 10 shows code upper half
// - window 11 shows code lower part
// - window 00 restores standard mapping
// - code and data share flash cells
// - ram code map committed by D4
// - serial mode always maps ram
// - boot rom shown over flash when committed
// - serial mode boot rom fixed ranges
// - serial mode boot map forced one
// - first control double buffered, view shows shadow
// - standby bit written only from ram
// - interrupt via flash vector clears standby
module fmpc_ctrl
  import fmpc_pkg::*;
(
  input  wire logic        pclk,            // system clock
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [15:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error, unmapped address
  input  wire logic        serial_mode_pin, // strap, asynchronous
  input  wire logic        exec_in_ram,     // current instruction runs from ram
  input  wire logic        irq_take,        // interrupt vector fetch begins
  input  wire fmpc_acc_s   core_acc,        // core memory access
  input  wire fmpc_cmd_s   cmd_in,          // command write toward flash
  input  wire logic        toggle_req,      // toggle status read toward flash
  output fmpc_map_s        mem_sel,         // resolved target of core_acc
  output fmpc_cmd_s        flash_cmd,       // command write passed to flash
  output logic             flash_toggle,    // toggle read passed to flash
  output logic             flash_cmd_en,    // committed command enable
  output logic             flash_standby,   // flash_standby_request
  output logic             standby_reset,   // flash standby reset pulse
  output logic             clock_pin_input_enable,  // serial clock pin gate
  output logic             other_pins_input_enable  // remaining port gate
);

  // ************************************************************
  // mode strap synchroniser
  // ************************************************************
  logic [2:0] mode_sync_q;
  logic       serial_q;

  // second and third stages must agree before a change counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sync_q <= 3'h0;
    end else begin
      mode_sync_q <= {mode_sync_q[1:0], serial_mode_pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_q <= 1'b0;
    end else if (mode_sync_q[1] == mode_sync_q[2]) begin
      serial_q <= mode_sync_q[2];
    end
  end

  // ************************************************************
  // apb decode, one wait state so read data comes from a flop
  // ************************************************************
  logic       ready_q;
  logic       access;
  logic       wr_done;
  logic [7:0] wbyte;
  logic       hit;

  assign access  = psel & penable;
  assign wr_done = access & ready_q & pwrite;
  assign wbyte   = pwdata[7:0];
  assign hit     = (paddr == ADDR_CTRL1) || (paddr == ADDR_COMMIT) ||
                   (paddr == ADDR_STBY) || (paddr == ADDR_PGATE) ||
                   (paddr == ADDR_SYS3) || (paddr == ADDR_SYS4);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access & ~ready_q;
    end
  end

  // ************************************************************
  // first control register and its shadow
  // ************************************************************
  logic [7:0] ctrl1_q;
  logic [7:0] shadow_q;
  logic       commit_cr1;

  assign commit_cr1 = wr_done && paddr == ADDR_COMMIT && wbyte == KEY_CR1;

  // written value only; has no effect until committed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= CTRL1_RST;
    end else if (wr_done && paddr == ADDR_CTRL1) begin
      ctrl1_q <= wbyte;
    end
  end

  // any other commit value is ignored, shadow holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= CTRL1_RST;
    end else if (commit_cr1) begin
      shadow_q <= ctrl1_q;
    end
  end

  logic [1:0] area_act;
  logic       boot_act;
  logic       cmd_ok;

  assign area_act = shadow_q[AREA_LSB +: 2];
  assign boot_act = shadow_q[BOOT_BIT] | serial_q;
  assign cmd_ok   = shadow_q[MODE_LSB +: 3] == MODE_ENABLE;

  // ************************************************************
  // system control third and its commit
  // ************************************************************
  logic [7:0] sys3_q;
  logic       ram_map_q;
  logic       vec_ram_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys3_q <= 8'h00;
    end else if (wr_done && paddr == ADDR_SYS3) begin
      sys3_q <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_map_q <= 1'b0;
      vec_ram_q <= 1'b0;
    end else if (wr_done && paddr == ADDR_SYS4 && wbyte == KEY_SYS) begin
      ram_map_q <= sys3_q[RAM_MAP_BIT];
      vec_ram_q <= sys3_q[VEC_SEL_BIT];
    end
  end

  // ************************************************************
  // port input gate
  // ************************************************************
  logic [1:0] pgate_q;

  // writes outside serial mode are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgate_q <= 2'h0;
    end else if (wr_done && paddr == ADDR_PGATE && serial_q) begin
      pgate_q <= wbyte[1:0];
    end
  end

  // after reset in serial mode inputs stay fixed until software opens them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_pin_input_enable  <= 1'b1;
      other_pins_input_enable <= 1'b1;
    end else begin
      clock_pin_input_enable  <= ~serial_q | pgate_q[CLK_PIN_BIT];
      other_pins_input_enable <= ~serial_q | pgate_q[OTH_PIN_BIT];
    end
  end

  // ************************************************************
  // flash standby request
  // ************************************************************
  logic stby_wr;

  assign stby_wr = wr_done && paddr == ADDR_STBY && exec_in_ram;

  // vector fetch through flash must find the array awake, so clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_standby <= 1'b0;
    end else if (irq_take && !vec_ram_q) begin
      flash_standby <= 1'b0;
    end else if (stby_wr) begin
      flash_standby <= wbyte[0];
    end
  end

  // ************************************************************
  // address mapping
  // ************************************************************
  fmpc_map_s map_res;

  fmpc_map u_map (
    .acc       (core_acc),
    .serial    (serial_q),
    .boot_show (boot_act),
    .area      (area_act),
    .ram_map   (ram_map_q | serial_q),
    .res       (map_res)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_sel <= '0;
    end else begin
      mem_sel <= map_res;
    end
  end

  // a flash access while asleep; the interrupt clear above lands first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_reset <= 1'b0;
    end else begin
      standby_reset <= flash_standby && map_res.valid &&
                       map_res.tgt == TGT_FLASH && !(irq_take && !vec_ram_q);
    end
  end

  // ************************************************************
  // command gating
  // ************************************************************
  // only new writes are blocked; a sequence already inside the array runs on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cmd    <= '0;
      flash_toggle <= 1'b0;
      flash_cmd_en <= 1'b0;
    end else begin
      flash_cmd       <= cmd_in;
      flash_cmd.valid <= cmd_in.valid & cmd_ok;
      flash_toggle    <= toggle_req & cmd_ok;
      flash_cmd_en    <= cmd_ok;
    end
  end

  // ************************************************************
  // apb answer
  // ************************************************************
  logic [7:0] rbyte;
  logic [7:0] ctrl1_rd;
  logic [7:0] mon_rd;

  always_comb begin
    ctrl1_rd           = ctrl1_q;
    ctrl1_rd[BOOT_BIT] = ctrl1_q[BOOT_BIT] | serial_q;
    mon_rd                           = 8'h00;
    mon_rd[MON_MODE_BIT]             = cmd_ok;
    mon_rd[BOOT_BIT]                 = boot_act;
    mon_rd[AREA_LSB +: 2]            = area_act;
    mon_rd[ROMSEL_LSB +: 2]          = shadow_q[ROMSEL_LSB +: 2];
  end

  always_comb begin
    case (paddr)
      ADDR_CTRL1:  rbyte = ctrl1_rd;
      ADDR_COMMIT: rbyte = mon_rd;
      ADDR_STBY:   rbyte = 8'h00;
      ADDR_PGATE:  rbyte = serial_q ? (PGATE_RO | {6'h00, pgate_q}) : 8'h00;
      ADDR_SYS3:   rbyte = sys3_q;
      default:     rbyte = 8'h00;
    endcase
  end

  // data and error are captured in the wait cycle and stand with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~ready_q;
      pslverr <= access & ~ready_q & ~hit;
      if (access && !ready_q && !pwrite) begin
        prdata <= {24'h000000, rbyte};
      end
    end
  end

endmodule : fmpc_ctrl

// >>> core/fmpc_pkg.sv
// constants, types and register map of the flash map and protect controller
// assumes a 16-bit core address space and an APB slave with 32-bit data
package fmpc_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [11:0] IDX_CTRL1  = 12'hFD0; // flash_control_first
  localparam logic [11:0] IDX_COMMIT = 12'hFD1; // flash_commit_reg / shadow view
  localparam logic [11:0] IDX_STBY   = 12'hFD2; // flash_standby_reg
  localparam logic [11:0] IDX_PGATE  = 12'hFD3; // port_input_gate
  localparam logic [11:0] IDX_SYS3   = 12'hFD4; // system_control_third
  localparam logic [11:0] IDX_SYS4   = 12'hFD5; // system_commit_reg

  localparam logic [15:0] ADDR_CTRL1  = {2'b00, IDX_CTRL1, 2'b00};
  localparam logic [15:0] ADDR_COMMIT = {2'b00, IDX_COMMIT, 2'b00};
  localparam logic [15:0] ADDR_STBY   = {2'b00, IDX_STBY, 2'b00};
  localparam logic [15:0] ADDR_PGATE  = {2'b00, IDX_PGATE, 2'b00};
  localparam logic [15:0] ADDR_SYS3   = {2'b00, IDX_SYS3, 2'b00};
  localparam logic [15:0] ADDR_SYS4   = {2'b00, IDX_SYS4, 2'b00};

  // ************************************************************
  // fields, keys and reset values
  // ************************************************************
  localparam int          MODE_LSB     = 5;     // command enable code, 3 bits
  localparam int          BOOT_BIT     = 4;     // boot rom map
  localparam int          AREA_LSB     = 2;     // area window select, 2 bits
  localparam int          ROMSEL_LSB   = 0;     // rom select, 2 bits
  localparam int          MON_MODE_BIT = 5;     // shadow view: commands enabled
  localparam int          CLK_PIN_BIT  = 1;     // clock_pin_input_enable
  localparam int          OTH_PIN_BIT  = 0;     // other_pins_input_enable
  localparam int          RAM_MAP_BIT  = 0;     // ram_code_map
  localparam int          VEC_SEL_BIT  = 1;     // vector_location_select
  localparam logic [2:0]  MODE_ENABLE  = 3'h5;
  localparam logic [2:0]  MODE_DISABLE = 3'h2;
  localparam logic [7:0]  KEY_CR1      = 8'hD5;
  localparam logic [7:0]  KEY_SYS      = 8'hD4;
  localparam logic [7:0]  CTRL1_RST    = 8'h40;
  localparam logic [7:0]  PGATE_RO     = 8'hF0; // fixed upper bits of port_input_gate

  // ************************************************************
  // memory map
  // ************************************************************
  localparam logic [15:0] FLASH_LO     = 16'h1000;
  localparam logic [15:0] BOOT_LO      = 16'h1000;
  localparam logic [15:0] BOOT_HI      = 16'h17FF;
  localparam logic [15:0] BOOT_SER_HI  = 16'h1FFF;
  localparam logic [15:0] WIN_LO       = 16'h9000;
  localparam logic [15:0] WIN_OFS      = 16'h8000;
  localparam logic [15:0] RAM_CODE_LO  = 16'h0040;
  localparam logic [15:0] RAM_CODE_HI  = 16'h0FFF;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE} fmpc_kind_e;
  typedef enum logic [1:0] {TGT_NONE, TGT_FLASH, TGT_BOOT, TGT_RAM} fmpc_tgt_e;

  typedef struct packed {
    logic        valid;
    fmpc_kind_e  kind;
    logic [15:0] addr;
  } fmpc_acc_s;

  typedef struct packed {
    logic        valid;
    fmpc_tgt_e   tgt;
    logic [15:0] phys;
  } fmpc_map_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } fmpc_cmd_s;

endpackage : fmpc_pkg

// >>> core/fmpc_map.sv
// address resolver: logical code/data address to target and flash cell
// assumes committed map settings; purely combinational, caller registers
`timescale 1ns/1ns
module fmpc_map
  import fmpc_pkg::*;
(
  input  wire fmpc_acc_s acc,        // core access
  input  wire logic      serial,     // serial programming mode
  input  wire logic      boot_show,  // committed boot rom map
  input  wire logic [1:0] area,      // committed area window select
  input  wire logic      ram_map,    // active ram code map
  output fmpc_map_s      res         // resolved target
);

  // ************************************************************
  // resolve
  // ************************************************************
  logic [15:0] boot_code_hi;
  assign boot_code_hi = serial ? BOOT_SER_HI : BOOT_HI;

  // code and data share one flash cell per address at 0x1000 and up, except data at 0x9000 and up while area[0] is set
  always_comb begin
    res       = '0;
    res.valid = acc.valid;
    res.tgt   = TGT_NONE;
    res.phys  = acc.addr;
    if (acc.kind == ACC_FETCH) begin
      if (ram_map && acc.addr >= RAM_CODE_LO && acc.addr <= RAM_CODE_HI) begin
        res.tgt = TGT_RAM;
      end else if (boot_show && acc.addr >= BOOT_LO && acc.addr <= boot_code_hi) begin
        res.tgt = TGT_BOOT;
      end else if (acc.addr >= FLASH_LO) begin
        res.tgt = TGT_FLASH;
      end
    end else begin
      if (boot_show && acc.addr >= BOOT_LO && acc.addr <= BOOT_HI) begin
        res.tgt = TGT_BOOT;
      end else if (acc.addr >= FLASH_LO) begin
        res.tgt = TGT_FLASH;
        // 01 and 11 fold the upper window down by 0x8000; 10 and 00 are
        // identity because code and data upper halves are mirrors
        if (area[0] && acc.addr >= WIN_LO) begin
          res.phys = acc.addr - WIN_OFS;
        end else begin
          res.phys = acc.addr;
        end
      end
    end
  end

endmodule : fmpc_map

// >>> tb/fmpc_ctrl_checker.sv
// port checker for the flash map and protect controller
// assumes it is bound into fmpc_ctrl and sees only its ports
`timescale 1ns/1ns
module fmpc_ctrl_checker
  import fmpc_pkg::*;
(
  input wire logic        pclk,                    // clock
  input wire logic        presetn,                 // reset, active low
  input wire logic        psel,                    // apb select
  input wire logic        penable,                 // apb enable
  input wire logic        pwrite,                  // apb direction
  input wire logic [15:0] paddr,                   // apb address
  input wire logic [31:0] prdata,                  // apb read data
  input wire logic        pready,                  // apb ready
  input wire logic        serial_mode_pin,         // strap
  input wire logic        irq_take,                // vector fetch
  input wire fmpc_acc_s   core_acc,                // core access
  input wire fmpc_cmd_s   cmd_in,                  // command in
  input wire logic        toggle_req,              // toggle in
  input wire fmpc_cmd_s   flash_cmd,               // command out
  input wire logic        flash_toggle,            // toggle out
  input wire logic        flash_cmd_en,            // commands enabled
  input wire logic        flash_standby,           // standby bit
  input wire logic        standby_reset,           // standby reset
  input wire logic        clock_pin_input_enable,  // clock pin gate
  input wire logic        other_pins_input_enable  // other pins gate
);
  // ****************************************
  // strap settle count
  // ****************************************
  logic [2:0] ser_cnt_q;
  logic       ser_prev_q;
  // the strap is synchronised, so mode checks wait until it has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_cnt_q  <= 3'h0;
      ser_prev_q <= 1'b0;
    end else begin
      ser_prev_q <= serial_mode_pin;
      if (ser_prev_q != serial_mode_pin) ser_cnt_q <= 3'h0;
      else if (ser_cnt_q != 3'h7) ser_cnt_q <= ser_cnt_q + 3'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_rd(logic [15:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  property p_ready;
    s_setup |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after access");
  property p_stby_rd;
    s_rd(ADDR_STBY) |-> prdata == 32'h0;
  endproperty
  a_stby_rd: assert property (p_stby_rd) else $error("standby read not zero");
  property p_stby_rst;
    core_acc.valid && core_acc.addr >= 16'h2000 && flash_standby && !irq_take |=> standby_reset;
  endproperty
  a_stby_rst: assert property (p_stby_rst) else $error("no standby reset");
  property p_no_spur;
    standby_reset |-> $past(flash_standby) && $past(core_acc.valid);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("spurious standby reset");
  property p_cmd_pass;
    cmd_in.valid ##1 flash_cmd_en |-> flash_cmd.valid && flash_cmd.data == $past(cmd_in.data);
  endproperty
  a_cmd_pass: assert property (p_cmd_pass) else $error("enabled command lost");
  property p_cmd_drop;
    (cmd_in.valid || toggle_req) ##1 !flash_cmd_en |-> !flash_cmd.valid && !flash_toggle;
  endproperty
  a_cmd_drop: assert property (p_cmd_drop) else $error("disabled command passed");
  property p_pg_ser;
    ser_cnt_q == 3'h7 && serial_mode_pin ##0 s_rd(ADDR_PGATE) |->
      prdata[7:0] == {PGATE_RO[7:2], clock_pin_input_enable, other_pins_input_enable};
  endproperty
  a_pg_ser: assert property (p_pg_ser) else $error("pin gates differ from register");
  property p_pg_mcu;
    ser_cnt_q == 3'h7 && !serial_mode_pin |-> clock_pin_input_enable && other_pins_input_enable;
  endproperty
  a_pg_mcu: assert property (p_pg_mcu) else $error("port gated in normal mode");
  property p_pg_mcu_rd;
    ser_cnt_q == 3'h7 && !serial_mode_pin ##0 s_rd(ADDR_PGATE) |-> prdata == 32'h0;
  endproperty
  a_pg_mcu_rd: assert property (p_pg_mcu_rd) else $error("port gate read not zero");
  property p_boot_ser;
    ser_cnt_q == 3'h7 && serial_mode_pin ##0 s_rd(ADDR_COMMIT) |-> prdata[BOOT_BIT];
  endproperty
  a_boot_ser: assert property (p_boot_ser) else $error("boot map not one");
endmodule : fmpc_ctrl_checker

bind fmpc_ctrl fmpc_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .serial_mode_pin, .irq_take, .core_acc, .cmd_in, .toggle_req, .flash_cmd, .flash_toggle,
  .flash_cmd_en, .flash_standby, .standby_reset, .clock_pin_input_enable, .other_pins_input_enable);

// >>> tb/fmpc_flash_model.sv
// behavioural flash array: counts command writes and toggle reads
// assumes the controller drives flash_cmd and flash_toggle on pclk
`timescale 1ns/1ns
module fmpc_flash_model
  import fmpc_pkg::*;
(
  input  wire logic      pclk,          // clock
  input  wire logic      presetn,       // reset, active low
  input  wire fmpc_cmd_s flash_cmd,     // command write
  input  wire logic      flash_toggle,  // toggle read
  output logic [7:0]     cmd_cnt,       // commands taken
  output logic [7:0]     tog_cnt        // toggles taken
);
  // only what passes the write guard ever reaches the cells
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_cnt <= 8'h00;
      tog_cnt <= 8'h00;
    end else begin
      if (flash_cmd.valid) cmd_cnt <= cmd_cnt + 8'h01;
      if (flash_toggle) tog_cnt <= tog_cnt + 8'h01;
    end
  end
endmodule : fmpc_flash_model

// >>> tb/fmpc_ctrl_tb.sv
// self-checking bench for the flash map and protect controller
// assumes the checker binds itself and the flash model sits on the far side
`timescale 1ns/1ns
module fmpc_ctrl_tb;
  import fmpc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_mode_pin;
  logic        exec_in_ram, irq_take, toggle_req, flash_toggle, flash_cmd_en;
  logic        flash_standby, standby_reset, clk_en, oth_en;
  logic [15:0] paddr, a;
  logic [31:0] pwdata, prdata;
  fmpc_acc_s   core_acc;
  fmpc_cmd_s   cmd_in, flash_cmd;
  fmpc_map_s   mem_sel;
  logic [7:0]  cmd_cnt, tog_cnt;
  logic [8:0]  rd_q[$];
  logic [18:0] map_q[$];
  int          num_errors, checks, cyc, rst_cnt;

  fmpc_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_mode_pin, .exec_in_ram, .irq_take, .core_acc, .cmd_in, .toggle_req, .mem_sel,
    .flash_cmd, .flash_toggle, .flash_cmd_en, .flash_standby, .standby_reset,
    .clock_pin_input_enable(clk_en), .other_pins_input_enable(oth_en));
  fmpc_flash_model u_flash (.pclk, .presetn, .flash_cmd, .flash_toggle, .cmd_cnt, .tog_cnt);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************
  // compare tasks and result monitor
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cmp_map(input logic [18:0] e);
    chk("map target", {14'h0, e[17:16]}, {14'h0, mem_sel.tgt});
    if (e[18]) chk("map cell", e[15:0], mem_sel.phys);
  endtask : cmp_map
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // results are taken in issue order; a hang ends at the watchdog
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (standby_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (psel && penable && pready === 1'b1 && !pwrite) chk("apb read", {7'h0, rd_q.pop_front()},
      {7'h0, pslverr, prdata[7:0]});
    if (mem_sel.valid === 1'b1) cmp_map(map_q.pop_front());
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // ****************************************
  // drivers
  // ****************************************
  task automatic apb(input logic w, input logic [15:0] ad, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d);
  endtask : wr
  task automatic rd(input logic [15:0] ad, input logic [8:0] e);
    rd_q.push_back(e);
    apb(1'b0, ad, 8'h00);
  endtask : rd
  task automatic cfg(input logic [7:0] v);
    wr(ADDR_CTRL1, v);
    wr(ADDR_COMMIT, KEY_CR1);
  endtask : cfg
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt
  task automatic acc(input fmpc_kind_e k, input logic [15:0] ad, input logic c, input fmpc_tgt_e t,
                     input logic [15:0] p);
    map_q.push_back({c, t, p});
    @(posedge pclk);
    core_acc <= '{1'b1, k, ad};
    @(posedge pclk);
    core_acc.valid <= 1'b0;
  endtask : acc
  task automatic cmd();
    @(posedge pclk);
    cmd_in     <= '{1'b1, 16'h0555, 8'($urandom)};
    toggle_req <= 1'b1;
    @(posedge pclk);
    cmd_in.valid <= 1'b0;
    toggle_req   <= 1'b0;
    wt(2);
  endtask : cmd
  task automatic rst(input logic s);
    @(posedge pclk);
    presetn         <= 1'b0;
    serial_mode_pin <= s;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wt(8);
  endtask : rst

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, exec_in_ram, irq_take, toggle_req, serial_mode_pin} = '0;
    paddr = '0;
    pwdata = '0;
    core_acc = '0;
    cmd_in = '0;
    {num_errors, checks, cyc, rst_cnt} = '0;
    void'($urandom(32'h29794597));
    rst(1'b0);
    rd(ADDR_CTRL1, {1'b0, CTRL1_RST});
    rd(ADDR_STBY, 9'h000);
    wr(ADDR_PGATE, 8'h03);
    rd(ADDR_PGATE, 9'h000);
    rd(16'h0100, 9'h100);
    chk("pin gates", 16'h3, {14'h0, clk_en, oth_en});
    $display("test reset done");
    wr(ADDR_CTRL1, {MODE_ENABLE, 5'h00});
    cmd();
    chk("flash ops", 16'h0, {cmd_cnt, tog_cnt});
    rd(ADDR_COMMIT, 9'h000);
    wr(ADDR_COMMIT, 8'h55);
    rd(ADDR_COMMIT, 9'h000);
    wr(ADDR_COMMIT, KEY_CR1);
    rd(ADDR_COMMIT, 9'h020);
    cmd();
    cmd();
    chk("flash ops", 16'h0202, {cmd_cnt, tog_cnt});
    cfg({MODE_DISABLE, 5'h00});
    cmd();
    chk("flash ops", 16'h0202, {cmd_cnt, tog_cnt});
    $display("test command guard done");
    // every window setting, software not yet running from ram meanwhile
    for (int i = 0; i < 4; i++) begin
      a = 16'h9000 + 16'($urandom_range(28671));
      cfg({MODE_DISABLE, 1'b0, 2'(i), 2'b00});
      acc(ACC_READ, a, 1'b1, TGT_FLASH, (i % 2 == 1) ? a - WIN_OFS : a);
      acc(ACC_FETCH, a, 1'b1, TGT_FLASH, a);
    end
    acc(ACC_READ, 16'hC000, 1'b1, TGT_FLASH, 16'h4000);
    cfg({MODE_DISABLE, 1'b1, 4'h0});
    acc(ACC_READ, BOOT_HI, 1'b0, TGT_BOOT, 16'h0);
    acc(ACC_FETCH, 16'h1800, 1'b1, TGT_FLASH, 16'h1800);
    cfg(CTRL1_RST);
    acc(ACC_FETCH, BOOT_LO, 1'b1, TGT_FLASH, BOOT_LO);
    wr(ADDR_SYS3, 8'h01);
    wr(ADDR_SYS4, KEY_SYS);
    acc(ACC_FETCH, 16'h0200, 1'b0, TGT_RAM, 16'h0);
    wr(ADDR_SYS3, 8'h00);
    wr(ADDR_SYS4, KEY_SYS);
    acc(ACC_FETCH, 16'h0200, 1'b0, TGT_NONE, 16'h0);
    $display("test mapping done");
    wr(ADDR_STBY, 8'h01);
    exec_in_ram <= 1'b1;
    wt(1);
    chk("standby", 16'h0, {15'h0, flash_standby});
    wr(ADDR_STBY, 8'h01);
    wt(1);
    chk("standby", 16'h1, {15'h0, flash_standby});
    rd(ADDR_STBY, 9'h000);
    acc(ACC_READ, 16'h2000, 1'b1, TGT_FLASH, 16'h2000);
    irq_take <= 1'b1;
    @(posedge pclk);
    irq_take <= 1'b0;
    wt(1);
    chk("standby resets", 16'h1, 16'(rst_cnt));
    chk("standby", 16'h0, {15'h0, flash_standby});
    acc(ACC_READ, 16'h2000, 1'b1, TGT_FLASH, 16'h2000);
    wt(1);
    chk("standby resets", 16'h1, 16'(rst_cnt));
    $display("test standby done");
    rst(1'b1);
    chk("pin gates", 16'h0, {14'h0, clk_en, oth_en});
    wr(ADDR_PGATE, 8'h02);
    wt(2);
    chk("pin gates", 16'h2, {14'h0, clk_en, oth_en});
    rd(ADDR_PGATE, {1'b0, PGATE_RO | 8'h02});
    wr(ADDR_PGATE, 8'h01);
    wt(2);
    chk("pin gates", 16'h1, {14'h0, clk_en, oth_en});
    rd(ADDR_COMMIT, 9'h010);
    rd(ADDR_CTRL1, 9'h050);
    acc(ACC_FETCH, 16'h1C00, 1'b0, TGT_BOOT, 16'h0);
    acc(ACC_READ, 16'h1C00, 1'b1, TGT_FLASH, 16'h1C00);
    acc(ACC_FETCH, 16'h0200, 1'b0, TGT_RAM, 16'h0);
    $display("test serial mode done");
    wt(2);
    stop_test();
  end
endmodule : fmpc_ctrl_tb
